// ===== design/cal_pkg.sv
// package: constants, register map and carriers for the advance/limit block
package cal_pkg;

   // ------------------------------------------------------------
   // clock and advance timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;   // 100 MHz core clock
   localparam int ADV_STEP_US_X10  = 25;   // one advance step, 2.5 us
   localparam int ADV_STEP_CYC     = (ADV_STEP_US_X10 * 100) / CLK_PERIOD_NS;
   localparam int TICK_W           = 19;   // 250 * 15 << 7 fits
   localparam int AMP_W            = 9;    // drive and back-emf amplitude
   localparam int SPEED_W          = 16;
   localparam int NUM_W            = TICK_W + AMP_W;
   localparam logic [AMP_W-1:0] AMP_MAX = 9'h1ff;

   // ------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam int          ADDR_W    = 8;
   localparam logic [7:0]  OFS_ADV   = 8'h00;
   localparam logic [7:0]  OFS_LIMIT = 8'h04;
   localparam logic [7:0]  OFS_STAT  = 8'h08;
   localparam logic [7:0]  OFS_MASK  = 8'h0c;
   localparam logic [7:0]  OFS_STATE = 8'h10;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ADV_CODE_LSB  = 0;   // advance_time_code [6:0]
   localparam int ADV_VALUE_W   = 4;   // advance_base_value_field
   localparam int ADV_SHIFT_W   = 3;   // advance_shift_field
   localparam int ADV_MODE_BIT  = 8;   // advance_mode_select
   localparam int LIM_THR_LSB   = 0;   // soft_limit_threshold_field [3:0]
   localparam int LIM_RM_LSB    = 8;   // phase_resistance_setting [6:0]
   localparam int LIM_KT_LSB    = 16;  // back_emf_constant_setting [6:0]
   localparam int ST_LOCK_TRIP  = 0;   // lock_current_trip_flag
   localparam int ST_OCP        = 1;   // overcurrent_protection trip
   localparam int ST_ADV_DONE   = 2;   // advance point reached
   localparam int ST_W          = 3;
   localparam int STATE_LOCK    = 0;
   localparam int STATE_SLIM    = 1;
   localparam int STATE_ADV_LSB = 8;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [6:0]      RST_ADV_CODE = 7'h00;
   localparam logic            RST_ADV_MODE = 1'b0;
   localparam logic [3:0]      RST_LIM_THR  = 4'h0;
   localparam logic [6:0]      RST_RM       = 7'h00;
   localparam logic [6:0]      RST_KT       = 7'h00;
   localparam logic [ST_W-1:0] RST_MASK     = 3'h0;

   typedef enum logic {CAL_ADV_FIXED, CAL_ADV_VAR} cal_adv_mode_e;
   typedef enum logic [1:0] {CAL_IDLE, CAL_DIV, CAL_RUN} cal_adv_st_e;

   // configuration carrier
   typedef struct packed {
      cal_adv_mode_e adv_mode;
      logic [6:0]    adv_code;
      logic [3:0]    lim_thr;
      logic [6:0]    rm;
      logic [6:0]    kt;
   } cal_cfg_s;

endpackage

// ===== design/cal_core.sv
// module: commutation advance timer and current-limit control
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module cal_core (
   input  wire logic                          clk_i,
   input  wire logic                          resetn_i,
   input  wire logic [cal_pkg::ADDR_W-1:0]    addr_i,
   input  wire logic [31:0]                   wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic      [31:0]                   rdata_o,
   input  wire logic                          zc_event_i,
   input  wire logic [cal_pkg::AMP_W-1:0]     drive_amp_i,
   input  wire logic [cal_pkg::AMP_W-1:0]     bemf_amp_i,
   input  wire logic [cal_pkg::AMP_W-1:0]     demand_amp_i,
   input  wire logic [cal_pkg::SPEED_W-1:0]   speed_i,
   input  wire logic                          closed_loop_i,
   input  wire logic                          lock_trip_i,
   input  wire logic                          ocp_trip_i,
   input  wire logic                          restart_i,
   output logic                               adv_done_o,
   output logic      [cal_pkg::AMP_W-1:0]     amp_o,
   output logic                               drive_en_o,
   output logic                               irq_o
);
   import cal_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // base advance in clock ticks from the 7-bit code
   function automatic logic [TICK_W-1:0] adv_ticks(input logic [6:0] code);
      logic [TICK_W-1:0] base;
      base = TICK_W'(code[ADV_VALUE_W-1:0]) * TICK_W'(ADV_STEP_CYC);
      return base << code[ADV_VALUE_W +: ADV_SHIFT_W];
   endfunction

   // clamp a wide amplitude to the drive range
   function automatic logic [AMP_W-1:0] sat_amp(input logic [23:0] v);
      return (v > 24'(AMP_MAX)) ? AMP_MAX : v[AMP_W-1:0];
   endfunction

   cal_cfg_s              cfg_q;
   logic [ST_W-1:0]       stat_q;
   logic [ST_W-1:0]       mask_q;
   logic [ST_W-1:0]       stat_set;
   logic [ST_W-1:0]       stat_d;
   logic                  lock_q;
   logic                  slim_q;
   cal_adv_st_e           st_q;
   logic [TICK_W-1:0]     elapsed_q;
   logic [TICK_W-1:0]     target_q;
   logic [NUM_W-1:0]      num_q;
   logic [NUM_W-1:0]      quo_q;
   logic [AMP_W:0]        rem_q;
   logic [AMP_W-1:0]      vu_q;
   logic [4:0]            bit_q;
   logic [AMP_W:0]        rem_sh;
   logic [TICK_W-1:0]     base_ticks;
   logic [AMP_W-1:0]      cap_amp;
   logic                  wr_stat;
   logic                  adv_hit;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // software writes of advance and limit settings
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_q.adv_code <= RST_ADV_CODE;
         cfg_q.adv_mode <= cal_adv_mode_e'(RST_ADV_MODE);
         cfg_q.lim_thr  <= RST_LIM_THR;
         cfg_q.rm       <= RST_RM;
         cfg_q.kt       <= RST_KT;
      end else if (wr_i) begin
         if (addr_i == OFS_ADV) begin
            cfg_q.adv_code <= wdata_i[ADV_CODE_LSB +: 7];
            cfg_q.adv_mode <= cal_adv_mode_e'(wdata_i[ADV_MODE_BIT]);
         end
         if (addr_i == OFS_LIMIT) begin
            cfg_q.lim_thr <= wdata_i[LIM_THR_LSB +: 4];
            cfg_q.rm      <= wdata_i[LIM_RM_LSB +: 7];
            cfg_q.kt      <= wdata_i[LIM_KT_LSB +: 7];
         end
      end
   end

   // interrupt mask
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mask_q <= RST_MASK;
      end else if (wr_i && addr_i == OFS_MASK) begin
         mask_q <= wdata_i[ST_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // status, lock state and interrupt
   // ------------------------------------------------------------
   assign wr_stat = wr_i && (addr_i == OFS_STAT);
   assign stat_set[ST_LOCK_TRIP] = lock_trip_i;
   assign stat_set[ST_OCP]       = ocp_trip_i;
   assign stat_set[ST_ADV_DONE]  = adv_hit;
   // next flags: a written one clears, a new event wins
   assign stat_d = (stat_q & ~(wr_stat ? wdata_i[ST_W-1:0] : '0)) | stat_set;

   // sticky flags, write one to clear, a new event wins
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
      end
   end

   // lock state: either trip stops drive until restart
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock_q <= 1'b0;
      end else if (lock_trip_i || ocp_trip_i) begin
         lock_q <= 1'b1;
      end else if (restart_i) begin
         lock_q <= 1'b0;
      end
   end

   // level interrupt from unmasked flags
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_d & mask_q);
      end
   end

   // ------------------------------------------------------------
   // software current limit
   // ------------------------------------------------------------
   // cap from threshold, resistance, speed and back-emf constant
   assign cap_amp = sat_amp(24'(cfg_q.lim_thr) * 24'(cfg_q.rm)
                    + 24'(speed_i) * 24'(cfg_q.kt));

   // limited amplitude; only the amplitude changes, no fault raised
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         amp_o  <= '0;
         slim_q <= 1'b0;
      end else if (closed_loop_i && demand_amp_i > cap_amp) begin
         amp_o  <= cap_amp;
         slim_q <= 1'b1;
      end else begin
         amp_o  <= demand_amp_i;
         slim_q <= 1'b0;
      end
   end

   // drive enable follows lock state and the trip inputs, never the soft limit
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         drive_en_o <= 1'b0;
      end else begin
         drive_en_o <= !(lock_q || lock_trip_i || ocp_trip_i);
      end
   end

   // ------------------------------------------------------------
   // commutation advance timer
   // ------------------------------------------------------------
   assign base_ticks = adv_ticks(cfg_q.adv_code);
   assign rem_sh     = {rem_q[AMP_W-1:0], num_q[NUM_W-1]};
   assign adv_hit    = (st_q == CAL_RUN) && (elapsed_q >= target_q);

   // ticks elapsed since the last zero crossing
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         elapsed_q <= '0;
      end else if (zc_event_i) begin
         elapsed_q <= TICK_W'(1);
      end else if (st_q != CAL_IDLE && elapsed_q != '1) begin
         elapsed_q <= elapsed_q + TICK_W'(1);
      end
   end

   // target computation, divider for variable mode
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q     <= CAL_IDLE;
         target_q <= '0;
         num_q    <= '0;
         quo_q    <= '0;
         rem_q    <= '0;
         vu_q     <= '0;
         bit_q    <= '0;
      end else if (zc_event_i) begin
         rem_q <= '0;
         quo_q <= '0;
         vu_q  <= drive_amp_i;
         bit_q <= 5'(NUM_W - 1);
         num_q <= NUM_W'(base_ticks) * NUM_W'(drive_amp_i - bemf_amp_i);
         if (cfg_q.adv_mode == CAL_ADV_FIXED) begin
            target_q <= base_ticks;
            st_q     <= CAL_RUN;
         end else if (drive_amp_i == '0 || bemf_amp_i >= drive_amp_i) begin
            target_q <= '0; // no headroom, no advance
            st_q     <= CAL_RUN;
         end else begin
            st_q <= CAL_DIV;
         end
      end else begin
         case (st_q)
            CAL_IDLE: begin
               st_q <= CAL_IDLE;
            end
            CAL_DIV: begin
               num_q <= num_q << 1;
               if (rem_sh >= {1'b0, vu_q}) begin
                  rem_q <= rem_sh - {1'b0, vu_q};
                  quo_q <= {quo_q[NUM_W-2:0], 1'b1};
               end else begin
                  rem_q <= rem_sh;
                  quo_q <= {quo_q[NUM_W-2:0], 1'b0};
               end
               if (bit_q == '0) begin
                  st_q <= CAL_RUN;
                  target_q <= (rem_sh >= {1'b0, vu_q})
                     ? TICK_W'({quo_q[NUM_W-2:0], 1'b1})
                     : TICK_W'({quo_q[NUM_W-2:0], 1'b0});
               end else begin
                  bit_q <= bit_q - 5'h1;
               end
            end
            CAL_RUN: begin
               if (adv_hit) begin
                  st_q <= CAL_IDLE;
               end
            end
            default: begin
               st_q <= CAL_IDLE;
            end
         endcase
      end
   end

   // one-cycle pulse at the advance point
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         adv_done_o <= 1'b0;
      end else begin
         adv_done_o <= adv_hit && !zc_event_i;
      end
   end

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            OFS_ADV:   rdata_o <= 32'({cfg_q.adv_mode, 1'b0, cfg_q.adv_code});
            OFS_LIMIT: rdata_o <= 32'({1'b0, cfg_q.kt, 1'b0, cfg_q.rm,
                                       4'h0, cfg_q.lim_thr});
            OFS_STAT:  rdata_o <= 32'(stat_q);
            OFS_MASK:  rdata_o <= 32'(mask_q);
            OFS_STATE: rdata_o <= 32'({target_q, 6'h0, slim_q, lock_q});
            default:   rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_fixed_target;
      @(posedge clk_i) disable iff (!resetn_i)
      (zc_event_i && cfg_q.adv_mode == CAL_ADV_FIXED)
         |=> (target_q == $past(base_ticks) && st_q == CAL_RUN);
   endproperty
   a_fixed_target: assert property (p_fixed_target)
      else $error("fixed mode target differs from base ticks");

   property p_var_done;
      @(posedge clk_i) disable iff (!resetn_i)
      ($rose(st_q == CAL_DIV)) |-> ##[27:29] (st_q != CAL_DIV);
   endproperty
   a_var_done: assert property (p_var_done)
      else $error("divider length wrong");

   property p_var_bound;
      @(posedge clk_i) disable iff (!resetn_i)
      (st_q == CAL_DIV ##1 st_q == CAL_RUN) |-> (target_q <= base_ticks);
   endproperty
   a_var_bound: assert property (p_var_bound)
      else $error("variable advance exceeds base");

   property p_cap;
      @(posedge clk_i) disable iff (!resetn_i)
      closed_loop_i |=> (amp_o <= $past(cap_amp) &&
                         (amp_o == $past(demand_amp_i) ||
                          amp_o == $past(cap_amp)));
   endproperty
   a_cap: assert property (p_cap)
      else $error("closed loop amplitude above cap");

   property p_open_pass;
      @(posedge clk_i) disable iff (!resetn_i)
      !closed_loop_i |=> (amp_o == $past(demand_amp_i) && !slim_q);
   endproperty
   a_open_pass: assert property (p_open_pass)
      else $error("soft limit acted outside closed loop");

   property p_slim_nofault;
      @(posedge clk_i) disable iff (!resetn_i)
      (slim_q && !lock_q && !lock_trip_i && !ocp_trip_i)
         |=> (drive_en_o && !$rose(stat_q[ST_LOCK_TRIP]));
   endproperty
   a_slim_nofault: assert property (p_slim_nofault)
      else $error("soft limit stopped drive or faulted");

   property p_lock_trip;
      @(posedge clk_i) disable iff (!resetn_i)
      lock_trip_i |=> (!drive_en_o && lock_q && stat_q[ST_LOCK_TRIP]);
   endproperty
   a_lock_trip: assert property (p_lock_trip)
      else $error("lock trip did not stop and flag");

   property p_ocp;
      @(posedge clk_i) disable iff (!resetn_i)
      ocp_trip_i |=> (!drive_en_o && lock_q && stat_q[ST_OCP]);
   endproperty
   a_ocp: assert property (p_ocp)
      else $error("overcurrent did not stop and flag");

   property p_adv_time;
      @(posedge clk_i) disable iff (!resetn_i)
      adv_done_o |-> ($past(elapsed_q) >= $past(target_q));
   endproperty
   a_adv_time: assert property (p_adv_time)
      else $error("advance pulse before target");

   c_fixed: cover property (@(posedge clk_i) disable iff (!resetn_i)
      zc_event_i && cfg_q.adv_code != '0 ##[1:1000] adv_done_o);
   c_var: cover property (@(posedge clk_i) disable iff (!resetn_i)
      st_q == CAL_DIV ##[1:40] adv_done_o);
   c_slim: cover property (@(posedge clk_i) disable iff (!resetn_i)
      slim_q && drive_en_o);
   c_lock: cover property (@(posedge clk_i) disable iff (!resetn_i)
      lock_q ##1 restart_i ##2 drive_en_o);

endmodule

// ===== sim/cal_motor.sv
// motor windings model: zero crossings, back-emf and current trips
`timescale 1ns/1ps
module cal_motor (
   input  wire logic                      clk_i,
   input  wire logic                      drive_en_i,
   input  wire logic [cal_pkg::AMP_W-1:0] amp_i,
   input  wire logic                      zc_req_i,
   input  wire logic [cal_pkg::AMP_W-1:0] bemf_set_i,
   input  wire logic                      lock_req_i,
   input  wire logic                      ocp_req_i,
   output logic                           zc_event_o,
   output logic      [cal_pkg::AMP_W-1:0] drive_amp_o,
   output logic      [cal_pkg::AMP_W-1:0] bemf_amp_o,
   output logic                           lock_trip_o,
   output logic                           ocp_trip_o
);
   import cal_pkg::*;

   // --------------------------------------------------------
   // windings
   // --------------------------------------------------------
   // no crossing and no current while phases float
   assign zc_event_o  = zc_req_i & drive_en_i;
   assign drive_amp_o = drive_en_i ? amp_i : '0;
   assign bemf_amp_o  = drive_en_i ? bemf_set_i : '0;
   // current spikes only appear while the phases are driven
   assign lock_trip_o = lock_req_i & drive_en_i;
   assign ocp_trip_o  = ocp_req_i & drive_en_i;
endmodule

// ===== sim/tb_top.sv
// testbench: advance timing, soft limit, trips and interrupt
`timescale 1ns/1ps
module tb_top;
   import cal_pkg::*;

   // --------------------------------------------------------
   // signals
   // --------------------------------------------------------
   logic              clk_i = 1'b0;
   logic              resetn_i = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0]       wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              zc_req = 1'b0;
   logic [AMP_W-1:0]  bemf_set = '0;
   logic              lock_req = 1'b0;
   logic              ocp_req = 1'b0;
   logic [AMP_W-1:0]  demand = 9'h0c8;
   logic [SPEED_W-1:0] speed = '0;
   logic              closed_loop = 1'b0;
   logic              restart = 1'b0;
   logic [31:0]       rdata;
   logic              adv_done, drive_en, irq, zc, lt, ot;
   logic [AMP_W-1:0]  amp, vu, bemf;
   int                n_mismatch = 0;
   int                comparisons = 0;
   int                cyc = 0;
   int                cyc_zc = 0;
   logic              rd_seen = 1'b0;
   logic [31:0]       rq_exp[$];
   logic [31:0]       rq_msk[$];
   int                aq_lo[$];
   int                aq_hi[$];

   always #5 clk_i = ~clk_i;

   cal_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .zc_event_i(zc), .drive_amp_i(vu), .bemf_amp_i(bemf),
      .demand_amp_i(demand), .speed_i(speed), .closed_loop_i(closed_loop),
      .lock_trip_i(lt), .ocp_trip_i(ot), .restart_i(restart),
      .adv_done_o(adv_done), .amp_o(amp), .drive_en_o(drive_en),
      .irq_o(irq));

   cal_motor motor (.clk_i(clk_i), .drive_en_i(drive_en), .amp_i(amp),
      .zc_req_i(zc_req), .bemf_set_i(bemf_set), .lock_req_i(lock_req),
      .ocp_req_i(ocp_req), .zc_event_o(zc), .drive_amp_o(vu),
      .bemf_amp_o(bemf), .lock_trip_o(lt), .ocp_trip_o(ot));

   // --------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   // note the expected word; the monitor compares it a cycle later
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                         input logic [31:0] m);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      rq_exp.push_back(e & m);
      rq_msk.push_back(m);
      @(posedge clk_i);
      rd <= 1'b0;
   endtask

   task automatic pulse_zc();
      @(posedge clk_i);
      zc_req <= 1'b1;
      @(posedge clk_i);
      zc_req <= 1'b0;
   endtask

   // expect one advance pulse lo..hi cycles after the crossing
   task automatic zc_run(input int lo, input int hi);
      aq_lo.push_back(lo);
      aq_hi.push_back(hi);
      pulse_zc();
      for (int i = 0; i < hi + 4 && aq_lo.size() != 0; i++) begin
         @(posedge clk_i);
      end
      if (aq_lo.size() != 0) begin
         aq_lo.delete();
         aq_hi.delete();
         chk(32'h1, 32'h0);
      end
   endtask

   // --------------------------------------------------------
   // output monitor
   // --------------------------------------------------------
   always @(posedge clk_i) begin
      int d;
      int lo;
      int hi;
      cyc <= cyc + 1;
      rd_seen <= rd;
      if (zc === 1'b1) begin
         cyc_zc <= cyc;
      end
      if (rd_seen && rq_exp.size() != 0) begin
         chk(rdata & rq_msk.pop_front(), rq_exp.pop_front());
      end
      if (adv_done === 1'b1) begin
         if (aq_lo.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            d = cyc - cyc_zc;
            lo = aq_lo.pop_front();
            hi = aq_hi.pop_front();
            chk(32'((d >= lo && d <= hi) ? lo : d), 32'(lo));
         end
      end
   end

   // hang guard
   always @(posedge clk_i) begin
      if (cyc > 20000) begin
         n_mismatch++;
         results();
      end
   end

   // --------------------------------------------------------
   // main sequence
   // --------------------------------------------------------
   initial begin
      logic [7:0] offs[5];
      logic [3:0] thr;
      logic [6:0] rm;
      logic [6:0] kt;
      logic [8:0] dem;
      logic [15:0] spd;
      logic       cl;
      int         cap;
      offs = '{OFS_ADV, OFS_LIMIT, OFS_STAT, OFS_MASK, 8'h20};
      void'($urandom(32'he720));
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(32'(drive_en), 32'h1);
      foreach (offs[i]) begin
         rd_reg(offs[i], 32'h0, 32'hffffffff);
      end
      // fixed mode, zero code, and a restarted timer
      wr_reg(OFS_ADV, 32'h01);
      zc_run(251, 251);
      wr_reg(OFS_ADV, 32'h00);
      zc_run(2, 2);
      wr_reg(OFS_ADV, 32'h12);
      pulse_zc();
      repeat (100) @(posedge clk_i);
      zc_run(1001, 1001);
      // variable mode: 1000 ticks times 150/200, then back-emf above vu
      bemf_set <= 9'h032;
      wr_reg(OFS_ADV, 32'h104);
      zc_run(751, 790);
      bemf_set <= 9'h12c;
      zc_run(2, 40);
      rd_reg(OFS_STAT, 32'h4, 32'h4);
      wr_reg(OFS_STAT, 32'h7);
      // soft limit against random settings
      for (int k = 0; k < 16; k++) begin
         thr = 4'($urandom);
         rm = 7'($urandom);
         kt = 7'($urandom);
         spd = 16'($urandom % 8);
         dem = 9'($urandom);
         cl = (k % 4 != 0);
         cap = int'(thr) * int'(rm) + int'(spd) * int'(kt);
         if (cap > 511) begin
            cap = 511;
         end
         wr_reg(OFS_LIMIT, {9'h0, kt, 1'b0, rm, 4'h0, thr});
         @(posedge clk_i);
         demand <= dem;
         speed <= spd;
         closed_loop <= cl;
         repeat (2) @(posedge clk_i);
         chk(32'(amp), (cl && dem > cap) ? 32'(cap) : 32'(dem));
         chk(32'(drive_en), 32'h1);
      end
      rd_reg(OFS_STAT, 32'h0, 32'h7);
      // lock trip then overcurrent
      wr_reg(OFS_MASK, 32'h3);
      for (int t = 0; t < 2; t++) begin
         @(posedge clk_i);
         lock_req <= (t == 0);
         ocp_req <= (t == 1);
         @(posedge clk_i);
         lock_req <= 1'b0;
         ocp_req <= 1'b0;
         @(posedge clk_i);
         chk(32'(drive_en), 32'h0);
         chk(32'(irq), 32'h1);
         rd_reg(OFS_STAT, 32'(1 << t), 32'h7);
         rd_reg(OFS_STATE, 32'h1, 32'h1);
         wr_reg(OFS_MASK, 32'h0);
         repeat (2) @(posedge clk_i);
         chk(32'(irq), 32'h0);
         wr_reg(OFS_STAT, 32'h7);
         rd_reg(OFS_STAT, 32'h0, 32'h7);
         wr_reg(OFS_MASK, 32'h3);
         @(posedge clk_i);
         restart <= 1'b1;
         @(posedge clk_i);
         restart <= 1'b0;
         repeat (2) @(posedge clk_i);
         chk(32'(drive_en), 32'h1);
      end
      repeat (4) @(posedge clk_i);
      results();
   end
endmodule
